// ---- hw/csm_pkg.sv ----
// Shared constants and types for the stack engine and address map
package csm_pkg;
   localparam int CSM_DATA_W = 16;
   localparam int CSM_ADDR_W = 20;
   localparam int CSM_NREGS = 8;
   localparam int CSM_IDX_W = 3;
   localparam logic [15:0] CSM_STACK_STEP = 16'h0002;
   localparam logic [15:0] CSM_SS_RESET = 16'h0000;
   localparam logic [15:0] CSM_SP_RESET = 16'h0000;
   localparam logic [15:0] CSM_CS_RESET = 16'hFFFF;
   localparam logic [15:0] CSM_IP_RESET = 16'h0000;
   localparam logic [19:0] CSM_RESET_FETCH_ADDR = 20'hFFFF0;
   localparam logic [19:0] CSM_RESET_AREA_END = 20'hFFFFF;
   localparam logic [19:0] CSM_IVT_LO = 20'h00000;
   localparam logic [19:0] CSM_IVT_HI = 20'h003FF;
   localparam logic [15:0] CSM_COPROC_IO_LO = 16'h00F8;
   localparam logic [15:0] CSM_COPROC_IO_HI = 16'h00FF;
   localparam logic [2:0] CSM_ACC_IDX = 3'h0;

   typedef enum logic [3:0] {
      CSM_OP_NOP = 4'h0,
      CSM_OP_PUSH = 4'h1,
      CSM_OP_POP = 4'h2,
      CSM_OP_SET_SS = 4'h3,
      CSM_OP_SET_SP = 4'h4,
      CSM_OP_MEM_RD = 4'h5,
      CSM_OP_MEM_WR = 4'h6,
      CSM_OP_MEM_RMW = 4'h7,
      CSM_OP_IO_IN = 4'h8,
      CSM_OP_IO_OUT = 4'h9,
      CSM_OP_INC_REG = 4'hA,
      CSM_OP_REG_RD = 4'hB
   } csm_op_e;

   typedef enum logic [1:0] {
      CSM_ALU_ADD = 2'h0,
      CSM_ALU_SUB = 2'h1,
      CSM_ALU_SHL = 2'h2,
      CSM_ALU_CMP = 2'h3
   } csm_alu_e;

   typedef enum logic [2:0] {
      CSM_ST_IDLE = 3'h0,
      CSM_ST_PUSH_WR = 3'h1,
      CSM_ST_BUS = 3'h2,
      CSM_ST_REG_WAIT = 3'h3
   } csm_state_e;
endpackage

// ---- hw/csm_rf_if.sv ----
// Port bundle between the stack engine and its register file
interface csm_rf_if;
   logic [2:0] rd_idx;
   logic [15:0] rd_data;
   logic [2:0] wr_idx;
   logic wr_lo;
   logic wr_hi;
   logic [15:0] wr_data;
   modport core (output rd_idx, input rd_data, output wr_idx, output wr_lo, output wr_hi, output wr_data);
   modport mem (input rd_idx, output rd_data, input wr_idx, input wr_lo, input wr_hi, input wr_data);
endinterface

// ---- hw/csm_regfile.sv ----
// Eight 16-bit general registers with byte-lane writes and registered read
module csm_regfile
   import csm_pkg::*;
#(
   parameter int NREGS = CSM_NREGS
) (
   input wire logic mclk,
   csm_rf_if.mem rf
);
   logic [15:0] regs_r [NREGS];
   logic [15:0] rd_r;

   always_ff @(posedge mclk) begin
      if (rf.wr_lo) begin
         regs_r[rf.wr_idx][7:0] <= rf.wr_data[7:0];
      end
      if (rf.wr_hi) begin
         regs_r[rf.wr_idx][15:8] <= rf.wr_data[15:8];
      end
      rd_r <= regs_r[rf.rd_idx];
   end

   assign rf.rd_data = rd_r;
endmodule // csm_regfile

// ---- hw/csm_core.sv ----
// Stack engine, address generation and reserved address map of the core
// How it works
// - Stack entries move only as whole 16-bit words.
// - Push lowers the stack pointer by two, then writes the word.
// - Pop reads the top word, then raises the stack pointer by two.
// - Stack offset wraps within one 64 KB segment.
// - Entries are never moved or erased; only the stack pointer moves.
// - Exactly one stack is addressed, chosen by stack segment and pointer.
// - First fetch after reset is from 0FFFF0H; up to 0FFFFFH is reset code.
// - Memory 0H to 3FFH is the interrupt vector table, not code.
// - I/O ports 0F8H to 0FFH belong to the numeric coprocessor only.
// - Immediate operands are sources only; immediate destination is invalid.
// - Operations support byte and word sizes; operands interchangeable.
// - Arithmetic and shift act on memory by read-modify-write; compare only reads.
// - Port transfers move data only to or from the accumulator.
// - Eight one-byte increments, one per 16-bit general register.
// - Every memory access uses a 20-bit physical address.
// - Stack accesses use stack segment and pointer, never an override.
module csm_core
   import csm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire csm_pkg::csm_op_e cmd_op,
   input wire csm_pkg::csm_alu_e cmd_alu,
   input wire logic cmd_word,
   input wire logic cmd_dst_imm,
   input wire logic [2:0] cmd_reg,
   input wire logic [15:0] cmd_seg,
   input wire logic [15:0] cmd_off,
   input wire logic [15:0] cmd_data,
   output logic rsp_valid,
   output logic rsp_err,
   output logic [15:0] rsp_data,
   output logic bus_req,
   output logic bus_we,
   output logic bus_io,
   output logic bus_word,
   output logic [19:0] bus_addr,
   output logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata,
   input wire logic bus_ack,
   output logic [15:0] stack_pointer,
   output logic [15:0] stack_seg,
   output logic [19:0] top_of_stack,
   output logic ivt_hit,
   output logic reset_area_hit,
   output logic coproc_io_sel
);
   csm_rf_if rf ();
   csm_regfile #(.NREGS(CSM_NREGS)) u_rf (.mclk(mclk), .rf(rf));

   csm_state_e state_r, state_nxt;
   csm_op_e op_r, op_nxt;
   csm_alu_e alu_r, alu_nxt;
   logic [15:0] ss_r, ss_nxt, sp_r, sp_nxt, wdata_r, wdata_nxt, rdata_m, alu_res;
   logic [19:0] addr_r, addr_nxt, tos_r, tos_nxt;
   logic [2:0] reg_r, reg_nxt;
   logic word_r, word_nxt, req_r, req_nxt, we_r, we_nxt, io_r, io_nxt;
   logic rdy_r, rdy_nxt, rv_r, rv_nxt, rerr_r, rerr_nxt;
   logic [15:0] rdat_r, rdat_nxt;
   logic ivt_r, ivt_nxt, rst_area_r, rst_area_nxt, cop_r, cop_nxt;
   logic [2:0] rf_rd_idx, rf_wr_idx;
   logic rf_wr_lo, rf_wr_hi;
   logic [15:0] rf_wr_data;
   logic accept;

   // Segment shifted by four plus offset, carry out dropped
   function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] off);
      phys = {seg, 4'h0} + {4'h0, off};
   endfunction

   assign accept = cmd_valid && rdy_r;
   assign rdata_m = word_r ? bus_rdata : {8'h00, bus_rdata[7:0]};

   always_comb begin
      unique case (alu_r)
         CSM_ALU_ADD: alu_res = rdata_m + wdata_r;
         CSM_ALU_SUB: alu_res = rdata_m - wdata_r;
         CSM_ALU_SHL: alu_res = {rdata_m[14:0], 1'b0};
         CSM_ALU_CMP: alu_res = rdata_m - wdata_r;
      endcase
      if (!word_r) begin
         alu_res = {8'h00, alu_res[7:0]};
      end
   end

   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      alu_nxt = alu_r;
      ss_nxt = ss_r;
      sp_nxt = sp_r;
      wdata_nxt = wdata_r;
      addr_nxt = addr_r;
      reg_nxt = reg_r;
      word_nxt = word_r;
      req_nxt = req_r;
      we_nxt = we_r;
      io_nxt = io_r;
      rdy_nxt = rdy_r;
      rv_nxt = 1'b0;
      rerr_nxt = 1'b0;
      rdat_nxt = rdat_r;
      rf_rd_idx = cmd_reg;
      rf_wr_idx = CSM_ACC_IDX;
      rf_wr_lo = 1'b0;
      rf_wr_hi = 1'b0;
      rf_wr_data = rdata_m;
      unique case (state_r)
         CSM_ST_IDLE: begin
            if (accept) begin
               op_nxt = cmd_op;
               alu_nxt = cmd_alu;
               reg_nxt = cmd_reg;
               word_nxt = cmd_word;
               wdata_nxt = cmd_word ? cmd_data : {8'h00, cmd_data[7:0]};
               rdy_nxt = 1'b0;
               io_nxt = 1'b0;
               if (cmd_dst_imm) begin
                  rv_nxt = 1'b1;
                  rerr_nxt = 1'b1;
                  rdy_nxt = 1'b1;
               end else begin
                  unique case (cmd_op)
                     CSM_OP_PUSH: begin
                        sp_nxt = sp_r - CSM_STACK_STEP;
                        word_nxt = 1'b1;
                        wdata_nxt = cmd_data;
                        state_nxt = CSM_ST_PUSH_WR;
                     end
                     CSM_OP_POP: begin
                        addr_nxt = phys(ss_r, sp_r);
                        word_nxt = 1'b1;
                        req_nxt = 1'b1;
                        we_nxt = 1'b0;
                        state_nxt = CSM_ST_BUS;
                     end
                     CSM_OP_SET_SS, CSM_OP_SET_SP, CSM_OP_NOP: begin
                        if (cmd_op == CSM_OP_SET_SS) begin
                           ss_nxt = cmd_data;
                        end
                        if (cmd_op == CSM_OP_SET_SP) begin
                           sp_nxt = cmd_data;
                        end
                        rv_nxt = 1'b1;
                        rdy_nxt = 1'b1;
                     end
                     CSM_OP_MEM_RD, CSM_OP_MEM_WR, CSM_OP_MEM_RMW: begin
                        addr_nxt = phys(cmd_seg, cmd_off);
                        req_nxt = 1'b1;
                        we_nxt = (cmd_op == CSM_OP_MEM_WR);
                        state_nxt = CSM_ST_BUS;
                     end
                     CSM_OP_IO_IN: begin
                        addr_nxt = {4'h0, cmd_off};
                        io_nxt = 1'b1;
                        req_nxt = 1'b1;
                        we_nxt = 1'b0;
                        state_nxt = CSM_ST_BUS;
                     end
                     CSM_OP_IO_OUT: begin
                        rf_rd_idx = CSM_ACC_IDX;
                        addr_nxt = {4'h0, cmd_off};
                        io_nxt = 1'b1;
                        state_nxt = CSM_ST_REG_WAIT;
                     end
                     default: begin
                        state_nxt = CSM_ST_REG_WAIT;
                     end
                  endcase
               end
            end
         end
         CSM_ST_PUSH_WR: begin
            addr_nxt = phys(ss_r, sp_r);
            req_nxt = 1'b1;
            we_nxt = 1'b1;
            state_nxt = CSM_ST_BUS;
         end
         CSM_ST_REG_WAIT: begin
            if (op_r == CSM_OP_IO_OUT) begin
               wdata_nxt = word_r ? rf.rd_data : {8'h00, rf.rd_data[7:0]};
               req_nxt = 1'b1;
               we_nxt = 1'b1;
               state_nxt = CSM_ST_BUS;
            end else begin
               if (op_r == CSM_OP_INC_REG) begin
                  rf_wr_idx = reg_r;
                  rf_wr_lo = 1'b1;
                  rf_wr_hi = 1'b1;
                  rf_wr_data = rf.rd_data + 16'h0001;
               end
               rdat_nxt = rf.rd_data;
               rv_nxt = 1'b1;
               rdy_nxt = 1'b1;
               state_nxt = CSM_ST_IDLE;
            end
         end
         CSM_ST_BUS: begin
            if (bus_ack) begin
               req_nxt = 1'b0;
               rv_nxt = 1'b1;
               rdy_nxt = 1'b1;
               state_nxt = CSM_ST_IDLE;
               if (!we_r) begin
                  rdat_nxt = rdata_m;
               end
               if (op_r == CSM_OP_POP) begin
                  sp_nxt = sp_r + CSM_STACK_STEP;
               end
               if (op_r == CSM_OP_IO_IN) begin
                  rf_wr_lo = 1'b1;
                  rf_wr_hi = word_r;
               end
               if (op_r == CSM_OP_MEM_RMW && !we_r) begin
                  rdat_nxt = alu_res;
                  if (alu_r != CSM_ALU_CMP) begin
                     wdata_nxt = alu_res;
                     req_nxt = 1'b1;
                     we_nxt = 1'b1;
                     rv_nxt = 1'b0;
                     rdy_nxt = 1'b0;
                     state_nxt = CSM_ST_BUS;
                  end
               end
            end
         end
         default: begin
            state_nxt = CSM_ST_IDLE;
            rdy_nxt = 1'b1;
         end
      endcase
      tos_nxt = phys(ss_nxt, sp_nxt);
      ivt_nxt = req_nxt && !io_nxt && addr_nxt >= CSM_IVT_LO && addr_nxt <= CSM_IVT_HI;
      rst_area_nxt = req_nxt && !io_nxt && addr_nxt >= CSM_RESET_FETCH_ADDR
                     && addr_nxt <= CSM_RESET_AREA_END;
      cop_nxt = req_nxt && io_nxt && addr_nxt[15:0] >= CSM_COPROC_IO_LO
                && addr_nxt[15:0] <= CSM_COPROC_IO_HI && addr_nxt[19:16] == 4'h0;
   end

   assign rf.rd_idx = rf_rd_idx;
   assign rf.wr_idx = rf_wr_idx;
   assign rf.wr_lo = rf_wr_lo;
   assign rf.wr_hi = rf_wr_hi;
   assign rf.wr_data = rf_wr_data;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_r <= CSM_ST_BUS;
         op_r <= CSM_OP_NOP;
         alu_r <= CSM_ALU_ADD;
         ss_r <= CSM_SS_RESET;
         sp_r <= CSM_SP_RESET;
         wdata_r <= 16'h0000;
         addr_r <= CSM_RESET_FETCH_ADDR;
         tos_r <= 20'h00000;
         reg_r <= 3'h0;
         word_r <= 1'b1;
         req_r <= 1'b1;
         we_r <= 1'b0;
         io_r <= 1'b0;
         rdy_r <= 1'b0;
         rv_r <= 1'b0;
         rerr_r <= 1'b0;
         rdat_r <= 16'h0000;
         ivt_r <= 1'b0;
         rst_area_r <= 1'b1;
         cop_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         alu_r <= alu_nxt;
         ss_r <= ss_nxt;
         sp_r <= sp_nxt;
         wdata_r <= wdata_nxt;
         addr_r <= addr_nxt;
         tos_r <= tos_nxt;
         reg_r <= reg_nxt;
         word_r <= word_nxt;
         req_r <= req_nxt;
         we_r <= we_nxt;
         io_r <= io_nxt;
         rdy_r <= rdy_nxt;
         rv_r <= rv_nxt;
         rerr_r <= rerr_nxt;
         rdat_r <= rdat_nxt;
         ivt_r <= ivt_nxt;
         rst_area_r <= rst_area_nxt;
         cop_r <= cop_nxt;
      end
   end

   assign cmd_ready = rdy_r;
   assign rsp_valid = rv_r;
   assign rsp_err = rerr_r;
   assign rsp_data = rdat_r;
   assign bus_req = req_r;
   assign bus_we = we_r;
   assign bus_io = io_r;
   assign bus_word = word_r;
   assign bus_addr = addr_r;
   assign bus_wdata = wdata_r;
   assign stack_pointer = sp_r;
   assign stack_seg = ss_r;
   assign top_of_stack = tos_r;
   assign ivt_hit = ivt_r;
   assign reset_area_hit = rst_area_r;
   assign coproc_io_sel = cop_r;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   property p_stack_word;
      req_r && (op_r == CSM_OP_PUSH || op_r == CSM_OP_POP) |-> word_r && !io_r;
   endproperty
   a_stack_word: assert property (p_stack_word) else $error("stack access not a word");
   property p_push_order;
      accept && cmd_op == CSM_OP_PUSH && !cmd_dst_imm |=> sp_r == $past(sp_r) - 16'h0002 && !req_r
         ##1 req_r && we_r && bus_addr == phys(ss_r, sp_r);
   endproperty
   a_push_order: assert property (p_push_order) else $error("push not decrement then write");
   property p_pop_order;
      accept && cmd_op == CSM_OP_POP && !cmd_dst_imm |=> req_r && !we_r && sp_r == $past(sp_r);
   endproperty
   a_pop_order: assert property (p_pop_order) else $error("pop pointer moved before read");
   property p_pop_inc;
      state_r == CSM_ST_BUS && op_r == CSM_OP_POP && bus_ack |=> sp_r == $past(sp_r) + 16'h0002;
   endproperty
   a_pop_inc: assert property (p_pop_inc) else $error("pop did not raise pointer by two");
   property p_wrap;
      accept && cmd_op == CSM_OP_PUSH && !cmd_dst_imm && sp_r == 16'h0000 |=> sp_r == 16'hFFFE;
   endproperty
   a_wrap: assert property (p_wrap) else $error("stack pointer did not wrap");
   property p_tos;
      top_of_stack == phys(ss_r, sp_r);
   endproperty
   a_tos: assert property (p_tos) else $error("top of stack mismatch");
   property p_reset_fetch;
      $past(!rst_b) |-> req_r && !we_r && bus_addr == CSM_RESET_FETCH_ADDR && reset_area_hit;
   endproperty
   a_reset_fetch: assert property (p_reset_fetch) else $error("wrong first fetch");
   property p_imm_dst;
      accept && cmd_dst_imm |=> rsp_valid && rsp_err && !req_r && $stable(sp_r);
   endproperty
   a_imm_dst: assert property (p_imm_dst) else $error("immediate destination accepted");
   property p_coproc;
      req_r && io_r && bus_addr[15:0] >= 16'h00F8 && bus_addr[15:0] <= 16'h00FF |-> coproc_io_sel;
   endproperty
   a_coproc: assert property (p_coproc) else $error("coprocessor port not flagged");
   property p_ivt;
      req_r && !io_r && bus_addr <= 20'h003FF |-> ivt_hit;
   endproperty
   a_ivt: assert property (p_ivt) else $error("vector area not flagged");
endmodule // csm_core

// ---- tb/csm_mem_model.sv ----
// Memory and I/O space model answering the core's bus
module csm_mem_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic bus_io,
   input wire logic bus_word,
   input wire logic [19:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic [3:0] wait_cyc,
   output logic [15:0] bus_rdata,
   output logic bus_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [20:0]];
   logic [3:0] cnt;
   logic [20:0] k;

   function automatic logic [7:0] rd(input logic [20:0] a);
      return mem.exists(a) ? mem[a] : 8'h5A;
   endfunction

   initial begin
      bus_ack = 1'b0;
      bus_rdata = 16'h0000;
      cnt = 4'h0;
   end

   // Memory and I/O are separate spaces keyed by bus_io
   assign k = {bus_io, bus_addr};

   always @(posedge mclk) begin
      if (bus_ack || !rst_b || !bus_req) begin
         bus_ack <= 1'b0;
         bus_rdata <= ~bus_rdata;
         cnt <= 4'h0;
      end else if (cnt != wait_cyc) begin
         bus_rdata <= ~bus_rdata;
         cnt <= cnt + 4'h1;
      end else begin
         bus_ack <= 1'b1;
         if (bus_we) begin
            mem[k] = bus_wdata[7:0];
            if (bus_word) begin
               mem[k + 21'h1] = bus_wdata[15:8];
            end
         end else begin
            bus_rdata <= {rd(k + 21'h1), rd(k)};
         end
      end
   end
endmodule // csm_mem_model

// ---- tb/cpu_stack_and_memory_map_tb.sv ----
// Self-checking bench for the stack engine and address map
module cpu_stack_and_memory_map_tb;
   import csm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_b, cmd_valid, cmd_ready, cmd_word, cmd_dst_imm, rsp_valid, rsp_err;
   csm_op_e cmd_op;
   csm_alu_e cmd_alu;
   logic [2:0] cmd_reg;
   logic [15:0] cmd_seg, cmd_off, cmd_data, rsp_data, bus_wdata, bus_rdata, stack_pointer, stack_seg;
   logic bus_req, bus_we, bus_io, bus_word, bus_ack, ivt_hit, reset_area_hit, coproc_io_sel;
   logic [19:0] bus_addr, top_of_stack, cap_addr;
   logic [15:0] cap_wdata, r_data;
   logic cap_word, cap_ivt, cap_cop, r_err;
   logic [3:0] wait_cyc;
   int fail_count = 0;
   int checks_done = 0;
   int n_acc = 0;
   csm_alu_e alus [4] = '{CSM_ALU_ADD, CSM_ALU_SUB, CSM_ALU_SHL, CSM_ALU_CMP};
   logic [15:0] exps [4] = '{16'h1005, 16'h0FFB, 16'h2000, 16'h1000};

   csm_core csm_core_inst (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_alu(cmd_alu), .cmd_word(cmd_word), .cmd_dst_imm(cmd_dst_imm),
      .cmd_reg(cmd_reg), .cmd_seg(cmd_seg), .cmd_off(cmd_off), .cmd_data(cmd_data),
      .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data), .bus_req(bus_req),
      .bus_we(bus_we), .bus_io(bus_io), .bus_word(bus_word), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
      .stack_pointer(stack_pointer), .stack_seg(stack_seg), .top_of_stack(top_of_stack),
      .ivt_hit(ivt_hit), .reset_area_hit(reset_area_hit), .coproc_io_sel(coproc_io_sel));

   csm_mem_model csm_mem_model_inst (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req), .bus_we(bus_we),
      .bus_io(bus_io), .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .wait_cyc(wait_cyc), .bus_rdata(bus_rdata), .bus_ack(bus_ack));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Snapshot of each completed bus access
   always @(posedge mclk) begin
      if (bus_req === 1'b1 && bus_ack === 1'b1) begin
         cap_addr <= bus_addr;
         cap_word <= bus_word;
         cap_wdata <= bus_wdata;
         cap_ivt <= ivt_hit;
         cap_cop <= coproc_io_sel;
         n_acc <= n_acc + 1;
      end
   end

   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d, comparisons %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wait_rsp();
      int n;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      chk(rsp_valid, 1'b1);
      r_data = rsp_data;
      r_err = rsp_err;
   endtask

   task automatic do_cmd(input csm_op_e op, input logic [15:0] seg, input logic [15:0] off,
                         input logic [15:0] data, input logic word = 1'b1, input logic [2:0] rg = 3'h0,
                         input csm_alu_e alu = CSM_ALU_ADD, input logic dimm = 1'b0);
      int n;
      @(negedge mclk);
      cmd_op = op;
      cmd_seg = seg;
      cmd_off = off;
      cmd_data = data;
      cmd_word = word;
      cmd_reg = rg;
      cmd_alu = alu;
      cmd_dst_imm = dimm;
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
      cmd_valid = 1'b0;
      wait_rsp();
   endtask

   task automatic t_stack();
      do_cmd(CSM_OP_SET_SS, 16'h0000, 16'h0000, 16'h1234);
      do_cmd(CSM_OP_SET_SP, 16'h0000, 16'h0000, 16'h0002);
      do_cmd(CSM_OP_PUSH, 16'hFFFF, 16'h0100, 16'hBEEF, 1'b0);
      chk(stack_pointer, 16'h0000);
      chk(cap_addr, 20'h12340);
      chk(cap_word, 1'b1);
      chk(cap_wdata, 16'hBEEF);
      chk(top_of_stack, 20'h12340);
      do_cmd(CSM_OP_PUSH, 16'h0000, 16'h0000, 16'h1357);
      chk(stack_pointer, 16'hFFFE);
      chk(cap_addr, 20'h2233E);
      do_cmd(CSM_OP_POP, 16'h0000, 16'h0000, 16'h0000);
      chk(r_data, 16'h1357);
      chk(cap_addr, 20'h2233E);
      chk(stack_pointer, 16'h0000);
      do_cmd(CSM_OP_MEM_RD, 16'h1234, 16'hFFFE, 16'h0000);
      chk(r_data, 16'h1357);
      do_cmd(CSM_OP_POP, 16'h0000, 16'h0000, 16'h0000);
      chk(r_data, 16'hBEEF);
      chk(stack_pointer, 16'h0002);
      do_cmd(CSM_OP_SET_SS, 16'h0000, 16'h0000, 16'h2000);
      chk(top_of_stack, 20'h20002);
      chk(stack_seg, 16'h2000);
   endtask

   task automatic t_err();
      int n0;
      n0 = n_acc;
      do_cmd(CSM_OP_MEM_WR, 16'h0000, 16'h0500, 16'h1111, 1'b1, 3'h0, CSM_ALU_ADD, 1'b1);
      chk(r_err, 1'b1);
      chk(n_acc, n0);
      chk(stack_pointer, 16'h0002);
      do_cmd(CSM_OP_NOP, 16'h0000, 16'h0000, 16'h0000);
      chk(r_err, 1'b0);
      chk(n_acc, n0);
   endtask

   task automatic t_mem();
      wait_cyc = 4'h3;
      do_cmd(CSM_OP_MEM_WR, 16'hFFFF, 16'h0010, 16'hA55A);
      chk(cap_addr, 20'h00000);
      chk(cap_ivt, 1'b1);
      do_cmd(CSM_OP_MEM_WR, 16'h0000, 16'h03FF, 16'h3377, 1'b0);
      chk(cap_ivt, 1'b1);
      chk(cap_wdata, 16'h0077);
      do_cmd(CSM_OP_MEM_RD, 16'h0040, 16'h0000, 16'h0000);
      chk(cap_ivt, 1'b0);
      do_cmd(CSM_OP_MEM_RD, 16'h0000, 16'h0000, 16'h0000);
      chk(r_data, 16'hA55A);
      do_cmd(CSM_OP_MEM_RD, 16'h0000, 16'h03FF, 16'h0000, 1'b0);
      chk(r_data[7:0], 8'h77);
      wait_cyc = 4'h0;
   endtask

   task automatic t_rmw();
      for (int i = 0; i < 4; i++) begin
         do_cmd(CSM_OP_MEM_WR, 16'h0060, 16'h0000, 16'h1000);
         do_cmd(CSM_OP_MEM_RMW, 16'h0060, 16'h0000, 16'h0005, 1'b1, 3'h0, alus[i]);
         chk(r_data, (i == 3) ? 16'h0FFB : exps[i]);
         do_cmd(CSM_OP_MEM_RD, 16'h0060, 16'h0000, 16'h0000);
         chk(r_data, exps[i]);
      end
   endtask

   task automatic t_io();
      do_cmd(CSM_OP_IO_IN, 16'h0000, 16'h0010, 16'h0000);
      chk(r_data, 16'h4321);
      chk(cap_ivt, 1'b0);
      chk(cap_cop, 1'b0);
      do_cmd(CSM_OP_REG_RD, 16'h0000, 16'h0000, 16'h0000);
      chk(r_data, 16'h4321);
      do_cmd(CSM_OP_IO_IN, 16'h0000, 16'h0020, 16'h0000, 1'b0);
      do_cmd(CSM_OP_REG_RD, 16'h0000, 16'h0000, 16'h0000);
      chk(r_data, 16'h43AB);
      do_cmd(CSM_OP_INC_REG, 16'h0000, 16'h0000, 16'h0000);
      chk(r_data, 16'h43AB);
      do_cmd(CSM_OP_REG_RD, 16'h0000, 16'h0000, 16'h0000);
      chk(r_data, 16'h43AC);
      // Stand-in coprocessor port access
      do_cmd(CSM_OP_IO_OUT, 16'h0000, 16'h00F8, 16'h9999);
      chk(cap_addr, 20'h000F8);
      chk(cap_cop, 1'b1);
      chk(cap_wdata, 16'h43AC);
      do_cmd(CSM_OP_IO_OUT, 16'h0000, 16'h0100, 16'h9999);
      chk(cap_cop, 1'b0);
   endtask

   initial begin
      #100us;
      fail_count++;
      report_and_stop();
   end

   initial begin
      rst_b = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = CSM_OP_NOP;
      cmd_alu = CSM_ALU_ADD;
      cmd_word = 1'b1;
      cmd_dst_imm = 1'b0;
      cmd_reg = 3'h0;
      cmd_seg = 16'h0000;
      cmd_off = 16'h0000;
      cmd_data = 16'h0000;
      wait_cyc = 4'h0;
      // Reset code only in the high area, ports for the I/O checks
      csm_mem_model_inst.mem[21'h0FFFF0] = 8'hDE;
      csm_mem_model_inst.mem[21'h0FFFF1] = 8'hC0;
      csm_mem_model_inst.mem[21'h100010] = 8'h21;
      csm_mem_model_inst.mem[21'h100011] = 8'h43;
      csm_mem_model_inst.mem[21'h100020] = 8'hAB;
      repeat (20) @(negedge mclk);
      chk(bus_req, 1'b1);
      chk(bus_addr, 20'hFFFF0);
      chk(reset_area_hit, 1'b1);
      chk(top_of_stack, 20'h00000);
      rst_b = 1'b1;
      wait_rsp();
      chk(r_data, 16'hC0DE);
      t_stack();
      t_err();
      t_mem();
      t_rmw();
      t_io();
      report_and_stop();
   end
endmodule // cpu_stack_and_memory_map_tb
